// ### verilog/switcher_softstart_overload_ctrl.sv
// Soft-start, pulse skipping and overload auto-restart supervisor.
// Functional notes
// R1 - Soft-start raises current limit setpoint from zero to full in 8 equal steps.
// R2 - Full soft-start ramp lasts 8 ms.
// R3 - Every start-up attempt and every fault begins a new soft-start.
// R4 - Overcurrent inside minimum on-time skips the following switching cycle.
// R5 - Skipping halves switching rate, never below about 15 kHz.
// R6 - No overcurrent inside minimum on-time restores nominal switching rate.
// R7 - Each cycle reaching full current limit increments overcurrent counter.
// R8 - Trip overload protection when counter reaches end of count (50 ms).
// R9 - On trip switch off and stay disabled for about 1 s.
// R10 - After restart interval resume switching; repeat trip cycle if overload persists.
// R11 - Every restart after trip starts with a full soft-start ramp.
// R12 - Overload gone before trip: counter decrements one per cycle to zero.
// R13 - Fault clearing during restart interval still waits the full interval.
// R14 - Overload time counted in switching cycles; skipping stretches it to 100 ms.
// R15 - Terminal count equals 50 ms times 30 kHz; counter never wraps below zero.
`timescale 1ns/1ps
`include "switch_supervisor_defs.svh"

module switcher_softstart_overload_ctrl
  import switch_supervisor_pkg::*;
#(
  parameter int SETPOINT_W     = 8,
  parameter int PERIOD_CYCLES  = `PERIOD_CYCLES,
  parameter int MIN_ON_CYCLES  = `MIN_ON_CYCLES,
  parameter int SS_STEP_PERIODS = `SS_STEP_PERIODS,
  parameter int OVL_TRIP_COUNT = `OVL_TRIP_COUNT,
  parameter int RESTART_CYCLES = `RESTART_CYCLES,
  parameter logic [SETPOINT_W-1:0] FULL_LIMIT = 8'hF8
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  overcurrent_comparator_in,
  output logic                       gate_enable_out,
  output logic [SETPOINT_W-1:0]      current_limit_out,
  output logic                       overload_protection_out,
  output logic                       skip_active_out
);

  // ===========================================================================
  // Input synchroniser and local widths
  // ===========================================================================
  localparam int PW = $clog2(PERIOD_CYCLES + 1);
  localparam int SW = $clog2(SS_STEP_PERIODS + 1);
  localparam int OW = $clog2(OVL_TRIP_COUNT + 1);
  localparam int RW = $clog2(RESTART_CYCLES + 1);
  localparam logic [SETPOINT_W-1:0] STEP_SIZE =
    SETPOINT_W'(FULL_LIMIT / `SOFT_START_STEPS);

  logic oc_meta_q;
  logic oc_sync_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oc_meta_q <= 1'b0;
      oc_sync_q <= 1'b0;
    end else begin
      oc_meta_q <= overcurrent_comparator_in;
      oc_sync_q <= oc_meta_q;
    end
  end

  // ===========================================================================
  // State and counters
  // ===========================================================================
  sup_state_e            state_q, state_d;
  logic [PW-1:0]         phase_q;
  logic [SW-1:0]         ss_div_q;
  logic [3:0]            ss_step_q;
  logic [OW-1:0]         ovl_cnt_q, ovl_cnt_d;
  logic [RW-1:0]         restart_q;
  logic                  skip_cur_q;
  logic                  oc_seen_q;
  logic                  early_oc_q;
  logic                  on_q;

  wire period_end   = (phase_q == PW'(PERIOD_CYCLES - 1));
  wire in_min_on    = (phase_q < PW'(MIN_ON_CYCLES));
  wire switching    = (state_q != ST_RESTART_WAIT);
  wire active_cycle = switching && !skip_cur_q;
  wire ss_done      = (ss_step_q == 4'(`SOFT_START_STEPS));
  wire trip         = period_end && active_cycle && oc_seen_q
                      && (ovl_cnt_q == OW'(OVL_TRIP_COUNT - 1));
  wire restart_done = (restart_q == RW'(RESTART_CYCLES - 1));
  // An early hit in a live cycle drops the gate pulse of the very next cycle.
  wire skip_due     = active_cycle && early_oc_q;

  // Counter moves once per unskipped switching cycle, so skipped cycles lengthen the trip time.
  always_comb begin
    ovl_cnt_d = ovl_cnt_q;
    if (period_end && active_cycle) begin // R14
      if (oc_seen_q) begin
        ovl_cnt_d = ovl_cnt_q + OW'(1); // R7
      end else if (ovl_cnt_q != '0) begin
        ovl_cnt_d = ovl_cnt_q - OW'(1); // R12 R15
      end
    end
    if (trip) begin
      ovl_cnt_d = '0;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SOFT_START:   if (trip) state_d = ST_RESTART_WAIT; else if (ss_done) state_d = ST_RUN;
      ST_RUN:          if (trip) state_d = ST_RESTART_WAIT; // R8
      ST_RESTART_WAIT: if (restart_done) state_d = ST_SOFT_START; // R10 R11 R13
      default:         state_d = ST_SOFT_START;
    endcase
  end

  // Reset lands in soft-start, so every power-up attempt ramps from zero.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q   <= ST_SOFT_START; // R3
      ovl_cnt_q <= '0;
    end else begin
      state_q   <= state_d;
      ovl_cnt_q <= ovl_cnt_d;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q <= '0;
    end else if (period_end || !switching) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + PW'(1);
    end
  end

  // ===========================================================================
  // Soft-start ramp
  // ===========================================================================
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ss_div_q  <= '0;
      ss_step_q <= '0;
    end else if (state_q != ST_SOFT_START) begin
      ss_div_q  <= '0;
      ss_step_q <= (state_q == ST_RUN) ? 4'(`SOFT_START_STEPS) : 4'h0; // R3 R11
    end else if (period_end && !ss_done) begin
      if (ss_div_q == SW'(SS_STEP_PERIODS - 1)) begin
        ss_div_q  <= '0;
        ss_step_q <= ss_step_q + 4'h1; // R1 R2
      end else begin
        ss_div_q <= ss_div_q + SW'(1);
      end
    end
  end

  wire [SETPOINT_W-1:0] ramp_limit = ss_done ? FULL_LIMIT
                                   : SETPOINT_W'(ss_step_q * STEP_SIZE);

  // ===========================================================================
  // Pulse skipping
  // ===========================================================================
  // Only one cycle in two may be skipped, which floors the rate at half nominal.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oc_seen_q  <= 1'b0;
      early_oc_q <= 1'b0;
      skip_cur_q <= 1'b0;
    end else if (!switching) begin
      oc_seen_q  <= 1'b0;
      early_oc_q <= 1'b0;
      skip_cur_q <= 1'b0;
    end else if (period_end) begin
      oc_seen_q  <= 1'b0;
      early_oc_q <= 1'b0;
      skip_cur_q <= skip_due; // R4 R5 R6
    end else if (on_q && oc_sync_q) begin
      oc_seen_q  <= 1'b1;
      early_oc_q <= early_oc_q | in_min_on;
    end
  end

  // The switch opens on the first comparator hit, or at half period.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      on_q <= 1'b0;
    end else if (period_end) begin
      on_q <= switching && !skip_due && !trip; // R4 R6 R9
    end else if (!active_cycle || oc_sync_q || phase_q >= PW'(PERIOD_CYCLES / 2)) begin
      on_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      restart_q <= '0;
    end else if (state_q == ST_RESTART_WAIT) begin
      restart_q <= restart_q + RW'(1); // R13
    end else begin
      restart_q <= '0;
    end
  end

  // ===========================================================================
  // Outputs
  // ===========================================================================
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      current_limit_out       <= '0;
      overload_protection_out <= 1'b0;
      skip_active_out         <= 1'b0;
    end else begin
      // Keyed on the next state so the setpoint drops on the same edge the flag rises.
      current_limit_out       <= (state_d != ST_RESTART_WAIT) ? ramp_limit : '0; // R9
      overload_protection_out <= (state_d == ST_RESTART_WAIT); // R9
      skip_active_out         <= skip_cur_q;
    end
  end

  assign gate_enable_out = on_q;

  // ===========================================================================
  // Assertions
  // ===========================================================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence trip_seq;
    trip;
  endsequence

  gate_off_trip_a: assert property (trip_seq |=> !gate_enable_out) // R9
    else $error("gate still on after overload trip");
  wait_no_gate_a: assert property (state_q == ST_RESTART_WAIT |-> !on_q) // R13
    else $error("gate on during restart interval");
  restart_ramp_a: assert property ($rose(state_q == ST_SOFT_START) |-> ss_step_q == 4'h0) // R11
    else $error("restart did not begin ramp from zero");
  step_up_a: assert property ($changed(ss_step_q) && state_q == ST_SOFT_START
                              |-> ss_step_q == $past(ss_step_q) + 4'h1) // R1
    else $error("soft-start step not single");
  no_double_skip_a: assert property (period_end && skip_cur_q |=> !skip_cur_q) // R5
    else $error("two consecutive cycles skipped");
  cnt_no_wrap_a: assert property (ovl_cnt_q == '0 && !oc_seen_q |=> ovl_cnt_q == '0) // R15
    else $error("overcurrent counter wrapped");
  cnt_inc_a: assert property (period_end && active_cycle && oc_seen_q && !trip
                              |=> ovl_cnt_q == $past(ovl_cnt_q) + OW'(1)) // R7
    else $error("overcurrent counter did not increment");
  cnt_dec_a: assert property (period_end && active_cycle && !oc_seen_q
                              && ovl_cnt_q != '0 |=> ovl_cnt_q == $past(ovl_cnt_q) - OW'(1)) // R12
    else $error("overcurrent counter did not decrement");

  // ===========================================================================
  // Skipping, restart and ramp sequences
  // ===========================================================================
  sequence early_hit_seq;
    period_end && active_cycle && early_oc_q;
  endsequence

  sequence clean_end_seq;
    period_end && active_cycle && !early_oc_q && !trip;
  endsequence

  sequence restart_enter_seq;
    state_q != ST_RESTART_WAIT ##1 state_q == ST_RESTART_WAIT;
  endsequence

  skip_follow_a: assert property (early_hit_seq |=> skip_cur_q) // R4
    else $error("early overcurrent did not skip the next cycle");
  skip_gate_off_a: assert property (skip_cur_q |-> !gate_enable_out) // R4
    else $error("gate pulsed in a skipped cycle");
  restore_rate_a: assert property (clean_end_seq |=> !skip_cur_q && gate_enable_out) // R6
    else $error("nominal cycle not restored");
  trip_flag_a: assert property (trip_seq |=> overload_protection_out) // R8
    else $error("overload flag missing after trip");
  limit_off_a: assert property (overload_protection_out |-> current_limit_out == '0) // R9
    else $error("setpoint not zero during restart interval");
  gate_restart_a: assert property (overload_protection_out |-> !gate_enable_out) // R9
    else $error("gate on while overload flag high");
  restart_hold_a: assert property (state_q == ST_RESTART_WAIT && !restart_done
                                   |=> state_q == ST_RESTART_WAIT) // R13
    else $error("restart interval cut short");
  restart_count_a: assert property (restart_enter_seq |-> restart_q == '0) // R13
    else $error("restart interval did not count from zero");
  restart_soft_a: assert property (state_q == ST_RESTART_WAIT && restart_done
                                   |=> state_q == ST_SOFT_START && ss_step_q == 4'h0) // R10
    else $error("restart did not resume with soft-start");
  ramp_end_a: assert property (state_q == ST_SOFT_START && ss_done && !trip
                               |=> state_q == ST_RUN) // R1
    else $error("ramp did not finish at full limit");
  step_hold_a: assert property (state_q == ST_SOFT_START && !period_end
                                |=> $stable(ss_step_q)) // R2
    else $error("soft-start step moved inside a period");
  cnt_ceiling_a: assert property (ovl_cnt_q < OW'(OVL_TRIP_COUNT)) // R15
    else $error("overcurrent counter passed terminal count");

endmodule : switcher_softstart_overload_ctrl

// ### verilog/switch_supervisor_defs.svh
// Timing and setpoint constants for the switching-cycle supervisor.
`ifndef SWITCH_SUPERVISOR_DEFS_SVH
`define SWITCH_SUPERVISOR_DEFS_SVH

`define CLK_RATE_HZ            200000000
`define NOMINAL_SWITCH_RATE_HZ 30000
`define MINIMUM_SWITCH_RATE_HZ 15000
`define SOFT_START_TIME_MS     8
`define OVERLOAD_TRIP_TIME_MS  50
`define RESTART_TIME_MS        1000
`define SOFT_START_STEPS       8
`define MIN_ON_TIME_NS         400
// Cycles of clk_in per nominal switching period (shortest time, rounded down).
`define PERIOD_CYCLES          (`CLK_RATE_HZ / `NOMINAL_SWITCH_RATE_HZ)
// Minimum on-time in clock cycles (least time, rounded up).
`define MIN_ON_CYCLES          ((`MIN_ON_TIME_NS * (`CLK_RATE_HZ / 1000000) + 999) / 1000)
// Switching periods per soft-start step.
`define SS_STEP_PERIODS        \
  ((`SOFT_START_TIME_MS * `NOMINAL_SWITCH_RATE_HZ) / (1000 * `SOFT_START_STEPS))
// Overcurrent counter terminal count in switching cycles.
`define OVL_TRIP_COUNT         ((`OVERLOAD_TRIP_TIME_MS * `NOMINAL_SWITCH_RATE_HZ) / 1000)
// Restart interval in clock cycles.
`define RESTART_CYCLES         (`RESTART_TIME_MS * (`CLK_RATE_HZ / 1000))

`endif

// ### verilog/switch_supervisor_pkg.sv
// Types shared by the switching-cycle supervisor.
package switch_supervisor_pkg;
  typedef enum logic [1:0] {
    ST_SOFT_START,
    ST_RUN,
    ST_RESTART_WAIT
  } sup_state_e;
endpackage : switch_supervisor_pkg

// ### tb/drain_sense_model.sv
// Drain current-sense comparator model that follows the gate enable.
`timescale 1ns/1ps
module drain_sense_model (
  input  wire logic       clk_in,
  input  wire logic       gate_in,
  input  wire logic [1:0] mode_in,
  output logic            trip_out
);
  // ==========================================================================
  // On-time counter
  // Mode 0 never trips, mode 1 trips late in the on-time, mode 2 trips inside
  // the minimum on-time.
  logic [7:0] on_cnt_q;
  always_ff @(posedge clk_in) begin
    on_cnt_q <= gate_in ? on_cnt_q + 8'h01 : 8'h00;
  end
  // Current collapses once the switch opens, so the output never holds over.
  assign trip_out = gate_in && ((mode_in == 2'h1 && on_cnt_q >= 8'h1E) ||
                                (mode_in == 2'h2 && on_cnt_q >= 8'h02));
endmodule : drain_sense_model

// ### tb/switcher_softstart_overload_ctrl_test.sv
// Self-checking testbench for the switching-cycle supervisor.
`timescale 1ns/1ps
module switcher_softstart_overload_ctrl_test;
  localparam int PER = 200;
  localparam int STEP = 2;
  localparam int TRIP = 8;
  localparam int RST_CYC = 500;
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       comp;
  logic [1:0] mode = 2'h0;
  logic       gate;
  logic [7:0] limit;
  logic       overload_protection;
  logic       skip;
  logic       gate_prev = 1'b0;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         pulse_cnt = 0;
  int         rise_cyc = 0;
  int         pulse_gap = 0;

  always #2.5 clk_in = ~clk_in;

  switcher_softstart_overload_ctrl #(.PERIOD_CYCLES(PER), .MIN_ON_CYCLES(10),
    .SS_STEP_PERIODS(STEP), .OVL_TRIP_COUNT(TRIP), .RESTART_CYCLES(RST_CYC))
  u_switcher_softstart_overload_ctrl (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .overcurrent_comparator_in(comp),
    .gate_enable_out(gate), .current_limit_out(limit),
    .overload_protection_out(overload_protection), .skip_active_out(skip));

  drain_sense_model u_drain_sense_model (
    .clk_in(clk_in), .gate_in(gate), .mode_in(mode), .trip_out(comp));

  // ==========================================================================
  // Pulse monitor and timeout
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    gate_prev <= gate;
    if (gate === 1'b1 && gate_prev === 1'b0) begin
      pulse_cnt <= pulse_cnt + 1;
      pulse_gap <= cyc - rise_cyc;
      rise_cyc <= cyc;
    end
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic wait_pulses(input int n);
    int target;
    target = pulse_cnt + n;
    while (pulse_cnt < target) @(posedge clk_in);
  endtask : wait_pulses

  // ==========================================================================
  // Scenarios
  task automatic ramp_test();
    logic [7:0] old;
    int t0;
    for (int i = 1; i <= 8; i++) begin
      old = limit;
      while (limit === old) @(posedge clk_in);
      check("ramp step", limit, (i < 8) ? i * 31 : 32'hF8);
      if (i > 1) check("step time", cyc - t0, STEP * PER);
      t0 = cyc;
    end
    $display("ramp_test done");
  endtask : ramp_test

  task automatic skip_test();
    wait_pulses(1);
    mode <= 2'h2;
    wait_pulses(2);
    repeat (250) @(posedge clk_in);
    check("skip flag", skip, 1);
    wait_pulses(1);
    @(posedge clk_in);
    check("skip gap", pulse_gap, 2 * PER);
    mode <= 2'h0;
    wait_pulses(3);
    @(posedge clk_in);
    check("nominal gap", pulse_gap, PER);
    check("skip clear", skip, 0);
    wait_pulses(6);
    $display("skip_test done");
  endtask : skip_test

  task automatic overload_test();
    int base;
    int hold;
    logic bad;
    wait_pulses(1);
    mode <= 2'h1;
    wait_pulses(5);
    mode <= 2'h0;
    wait_pulses(8);
    check("no early trip", overload_protection, 0);
    mode <= 2'h1;
    base = pulse_cnt;
    while (overload_protection !== 1'b1) @(posedge clk_in);
    check("hits to trip", pulse_cnt - base + 1, TRIP);
    mode <= 2'h0;
    hold = 0;
    bad = 1'b0;
    while (overload_protection === 1'b1) begin
      hold++;
      if (gate !== 1'b0 || limit !== 8'h00) bad = 1'b1;
      @(posedge clk_in);
    end
    check("restart hold", hold, RST_CYC);
    check("off in restart", bad, 0);
    check("limit restart", limit, 0);
    base = pulse_cnt;
    while (limit === 8'h00) @(posedge clk_in);
    check("resumed", pulse_cnt > base, 1);
    check("first step", limit, 31);
    $display("overload_test done");
  endtask : overload_test

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    ramp_test();
    skip_test();
    overload_test();
    stop_test();
  end
endmodule : switcher_softstart_overload_ctrl_test
